// ### verilog/core_ops_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants for the instruction execution block
// ****************************************************************
package core_ops_pkg;
  // apb register byte offsets
  localparam logic [7:0] INSTR_OFS = 8'h00; // execute word / last word
  localparam logic [7:0] ACC_OFS = 8'h04; // accumulator
  localparam logic [7:0] STATUS_OFS = 8'h08; // status register
  localparam logic [7:0] WDOG_OFS = 8'h0C; // watchdog prescaler and count
  localparam logic [7:0] CTRL_OFS = 8'h10; // bit 0 starts interrupt entry
  localparam logic [7:0] PC_OFS = 8'h14; // program counter and stack pointer

  // widths
  localparam int INSTR_W = 14; // instruction word
  localparam int PC_W = 13; // program counter
  localparam int SP_W = 3; // stack pointer, eight levels
  localparam int MEM_AW = 8; // bank bit plus file address

  // opcode fields
  localparam logic [13:0] CLEAR_WDOG_WORD = 14'h0064; // watchdog clear
  localparam logic [5:0] COMPLEMENT_CODE = 6'h09; // bits 13:8
  localparam logic [5:0] SWAP_CODE = 6'h0E; // bits 13:8
  localparam logic [6:0] MOVE_CODE = 7'h01; // bits 13:7
  localparam logic [3:0] BIT_CLEAR_CODE = 4'h4; // bits 13:10
  localparam int DEST_BIT = 7; // destination select
  localparam int BIT_LSB = 7; // bit number field, bits 9:7

  // status register layout
  localparam logic [6:0] STATUS_ADDR = 7'h03; // status file address
  localparam int Z_BIT = 2; // zero flag
  localparam int PD_BIT = 3; // powerdown_flag, active low
  localparam int TO_BIT = 4; // watchdog_expiry_flag, active low
  localparam int BANK_BIT = 5; // bank_select_bit
  localparam logic [7:0] STATUS_RESET = 8'h18; // both flags high
  localparam logic [7:0] STATUS_WMASK = 8'hE7; // flag bits not writable
  localparam logic [12:0] INT_VECTOR = 13'h0004; // interrupt entry address

  // decoded operation, one-hot
  typedef enum logic [5:0] {
    OP_NONE = 6'h01,
    OP_CLEAR_WDOG = 6'h02,
    OP_COMPLEMENT = 6'h04,
    OP_SWAP = 6'h08,
    OP_MOVE = 6'h10,
    OP_BIT_CLEAR = 6'h20
  } op_e;

  // classify an instruction word
  function automatic op_e decode_op(input logic [13:0] w);
    if (w == CLEAR_WDOG_WORD) begin
      return OP_CLEAR_WDOG;
    end else if (w[13:8] == COMPLEMENT_CODE) begin
      return OP_COMPLEMENT;
    end else if (w[13:8] == SWAP_CODE) begin
      return OP_SWAP;
    end else if (w[13:7] == MOVE_CODE) begin
      return OP_MOVE;
    end else if (w[13:10] == BIT_CLEAR_CODE) begin
      return OP_BIT_CLEAR;
    end else begin
      return OP_NONE;
    end
  endfunction

  // true for every mapped register offset
  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == INSTR_OFS) || (a == ACC_OFS) || (a == STATUS_OFS) ||
           (a == WDOG_OFS) || (a == CTRL_OFS) || (a == PC_OFS);
  endfunction
endpackage
`default_nettype wire

// ### verilog/file_mem_if.sv
`default_nettype none
// ****************************************************************
// port between core and the banked register file memory
// ****************************************************************
interface file_mem_if;
  logic [7:0] addr; // bank bit and file address
  logic rd_en; // read strobe, data next cycle
  logic wr_en; // write strobe
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // registered read data
  modport core (output addr, output rd_en, output wr_en, output wdata, input rdata);
  modport mem (input addr, input rd_en, input wr_en, input wdata, output rdata);
endinterface
`default_nettype wire

// ### verilog/file_mem.sv
`default_nettype none
// ****************************************************************
// two banks of 128 bytes, registered read
// ****************************************************************
module file_mem
  import core_ops_pkg::*;
(
  input wire logic pclk,
  file_mem_if.mem port
);
  logic [7:0] cells [0:255]; // storage, no reset
  logic [7:0] rdata_q; // read register

  // write and registered read
  always_ff @(posedge pclk) begin
    if (port.wr_en) begin
      cells[port.addr] <= port.wdata;
    end
    if (port.rd_en) begin
      rdata_q <= cells[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule // file_mem
`default_nettype wire

// ### verilog/core_ops.sv
// Chosen here: the APB interface to the registers and the address map.
`default_nettype none
// What this block does
// - watchdog clear zeroes watchdog counter
// - watchdog clear zeroes prescaler too
// - watchdog clear sets expiry and powerdown flags
// - complement inverts register, updates zero flag
// - destination bit picks accumulator or register
// - swap exchanges register nibbles to destination
// - swap leaves all status flags alone unless status is its destination
// - move copies accumulator into register, any bank
// - clearing bank bit selects bank zero
// - interrupt entry pushes only return counter
module core_ops
  import core_ops_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************************************
  // core state
  // ****************************************************************
  logic [7:0] acc; // accumulator
  logic [7:0] status; // status register
  logic [7:0] watchdog_counter; // watchdog count
  logic [7:0] prescale; // watchdog prescaler
  logic [PC_W-1:0] pc; // program counter
  logic [SP_W-1:0] sp; // stack pointer
  logic [PC_W-1:0] stack [0:7]; // return address stack
  logic [INSTR_W-1:0] last_instr; // last executed word
  logic [7:0] next_acc;
  logic [7:0] next_status;
  logic [7:0] next_watchdog_counter;
  logic [7:0] next_prescale;
  logic [PC_W-1:0] next_pc;
  logic [SP_W-1:0] next_sp;
  logic [INSTR_W-1:0] next_last_instr;
  logic [31:0] next_prdata;

  // ****************************************************************
  // bus decode and instruction fields
  // ****************************************************************
  file_mem_if mem_port (); // register file link
  logic setup; // apb setup cycle
  logic access; // apb access cycle
  logic exec; // instruction runs this cycle
  logic irq_entry; // interrupt entry this cycle
  logic [13:0] word; // held instruction word
  op_e op; // decoded operation
  logic [6:0] faddr; // file address
  logic dest; // destination bit
  logic [2:0] bnum; // bit number for bit clear
  logic is_status; // file address hits status
  logic [7:0] operand; // addressed register value
  logic [7:0] result; // value to destination
  logic to_reg; // result goes to register

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign word = pwdata[INSTR_W-1:0];
  assign op = decode_op(word);
  assign faddr = word[6:0];
  assign dest = word[DEST_BIT];
  assign bnum = word[BIT_LSB+2:BIT_LSB];
  assign is_status = (faddr == STATUS_ADDR);
  // operation executes in the access cycle, operand is read in setup
  assign exec = access && pwrite && (paddr == INSTR_OFS);
  assign irq_entry = access && pwrite && (paddr == CTRL_OFS) && pwdata[0];
  assign pready = 1'h1; // no wait states
  assign pslverr = access && !reg_mapped(paddr);

  // bank bit extends every file address, read in setup
  assign mem_port.addr = {status[BANK_BIT], faddr};
  assign mem_port.rd_en = setup && pwrite && (paddr == INSTR_OFS);
  assign mem_port.wr_en = exec && to_reg && !is_status;
  assign mem_port.wdata = result;
  assign operand = is_status ? status : mem_port.rdata;

  file_mem u_mem (
    .pclk(pclk),
    .port(mem_port)
  );

  // ****************************************************************
  // result datapath
  // ****************************************************************
  always_comb begin
    result = operand;
    to_reg = 1'h0;
    case (op)
      OP_COMPLEMENT: begin
        result = ~operand;
        to_reg = dest;
      end
      OP_SWAP: begin
        result = {operand[3:0], operand[7:4]};
        to_reg = dest;
      end
      OP_MOVE: begin
        result = acc;
        to_reg = 1'h1;
      end
      OP_BIT_CLEAR: begin
        result = operand & ~(8'h01 << bnum);
        to_reg = 1'h1;
      end
      default: begin
        result = operand;
        to_reg = 1'h0;
      end
    endcase
  end

  // ****************************************************************
  // next state of the core
  // ****************************************************************
  always_comb begin
    next_acc = acc;
    next_status = status;
    next_pc = pc;
    next_sp = sp;
    next_last_instr = last_instr;
    // free running watchdog, clear wins over count
    next_prescale = prescale + 8'h01;
    next_watchdog_counter = (prescale == 8'hFF) ? watchdog_counter + 8'h01 : watchdog_counter;
    if (exec) begin
      next_pc = pc + 13'h0001;
      next_last_instr = word;
      // register write to status keeps the two flags
      if (to_reg && is_status) begin
        next_status = (result & STATUS_WMASK) | (status & ~STATUS_WMASK);
      end
      if ((op == OP_COMPLEMENT || op == OP_SWAP) && !to_reg) begin
        next_acc = result;
      end
      // only complement sets the zero flag from its result, swap changes status only when status is its destination
      if (op == OP_COMPLEMENT) begin
        next_status[Z_BIT] = (result == 8'h00);
      end
      if (op == OP_CLEAR_WDOG) begin
        next_watchdog_counter = 8'h00;
        next_prescale = 8'h00;
        next_status[TO_BIT] = 1'h1;
        next_status[PD_BIT] = 1'h1;
      end
    end else if (irq_entry) begin
      // only the return address is saved
      next_sp = sp + 3'h1;
      next_pc = INT_VECTOR;
    end else if (access && pwrite && paddr == ACC_OFS) begin
      next_acc = pwdata[7:0];
    end
  end

  // register the core state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
      status <= STATUS_RESET;
      watchdog_counter <= 8'h00;
      prescale <= 8'h00;
      pc <= 13'h0000;
      sp <= 3'h0;
      last_instr <= 14'h0000;
    end else begin
      acc <= next_acc;
      status <= next_status;
      watchdog_counter <= next_watchdog_counter;
      prescale <= next_prescale;
      pc <= next_pc;
      sp <= next_sp;
      last_instr <= next_last_instr;
    end
  end

  // stack cells, written only on interrupt entry
  always_ff @(posedge pclk) begin
    if (irq_entry) begin
      stack[sp] <= pc;
    end
  end

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  always_comb begin
    next_prdata = prdata;
    if (setup && !pwrite) begin
      case (paddr)
        INSTR_OFS: next_prdata = {18'h0, last_instr};
        ACC_OFS: next_prdata = {24'h000000, acc};
        STATUS_OFS: next_prdata = {24'h000000, status};
        WDOG_OFS: next_prdata = {16'h0000, prescale, watchdog_counter};
        PC_OFS: next_prdata = {16'h0000, sp, pc};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wdog_count_zero_a: assert property (exec && op == OP_CLEAR_WDOG |=> watchdog_counter == 8'h00)
    else $error("watchdog count not cleared");
  wdog_presc_zero_a: assert property (exec && op == OP_CLEAR_WDOG |=> prescale == 8'h00)
    else $error("prescaler not cleared");
  clear_flags_set_a: assert property (exec && op == OP_CLEAR_WDOG |=>
      status[TO_BIT] && status[PD_BIT] && status[7:5] == $past(status[7:5]) &&
      status[2:0] == $past(status[2:0]))
    else $error("watchdog clear flags wrong");
  complement_acc_a: assert property (exec && op == OP_COMPLEMENT && !dest |=>
      acc == ~$past(operand) && status[Z_BIT] == (acc == 8'h00))
    else $error("complement to accumulator wrong");
  complement_reg_a: assert property (exec && op == OP_COMPLEMENT && dest && !is_status |->
      mem_port.wr_en && mem_port.wdata == ~operand ##1 acc == $past(acc))
    else $error("complement to register wrong");
  swap_acc_a: assert property (exec && op == OP_SWAP && !dest |=>
      acc == {$past(operand[3:0]), $past(operand[7:4])})
    else $error("swap result wrong");
  swap_flags_a: assert property (exec && op == OP_SWAP && !(dest && is_status) |=>
      status == $past(status))
    else $error("swap changed status");
  move_write_a: assert property (exec && op == OP_MOVE && !is_status |->
      mem_port.wr_en && mem_port.wdata == acc && mem_port.addr[6:0] == faddr)
    else $error("move did not write accumulator");
  bank_clear_a: assert property (exec && op == OP_BIT_CLEAR && is_status &&
      bnum == 3'(BANK_BIT) |=> !status[BANK_BIT])
    else $error("bank bit not cleared");
  irq_entry_a: assert property (irq_entry |=> pc == INT_VECTOR &&
      acc == $past(acc) && status == $past(status) && sp == $past(sp) + 3'h1)
    else $error("interrupt entry saved wrong state");
  stack_push_a: assert property (irq_entry |=> stack[$past(sp)] == $past(pc))
    else $error("return address not pushed");
  one_cycle_a: assert property (exec |-> pready ##1 pc == $past(pc) + 13'h0001)
    else $error("operation not single cycle");

  clear_seen_c: cover property (exec && op == OP_CLEAR_WDOG);
  complement_reg_c: cover property (exec && op == OP_COMPLEMENT && dest);
  swap_status_c: cover property (exec && op == OP_SWAP && is_status && !dest);
  bank_zero_c: cover property (status[BANK_BIT] ##1 !status[BANK_BIT]);
endmodule // core_ops
`default_nettype wire

// ### bench/testbench.sv
`default_nettype none
// ****************************************************************
// bench for the instruction execution block
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import core_ops_pkg::*;
  logic pclk; // bus clock
  logic presetn; // reset, active low
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int err_count = 0; // mismatches
  int n_checks = 0; // comparisons
  int cycles = 0; // timeout counter
  logic [12:0] pc_exp = '0; // expected program counter
  logic [2:0] sp_exp = '0; // expected stack pointer
  logic [31:0] rd; // last read word
  logic er; // last error response

  core_ops uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one compare
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count = err_count + 1;
    end
  endtask

  // one apb transfer, setup then access until pready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare, error flag must be low
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, '0);
    check(nm, e, rd);
    check({nm, "_err"}, 32'h0, {31'h0, er});
  endtask

  // execute one instruction word
  task automatic exec(input logic [13:0] w);
    xfer(INSTR_OFS, 1'b1, {18'h0, w});
    pc_exp = pc_exp + 13'h0001;
  endtask

  // load the accumulator
  task automatic setacc(input logic [7:0] v);
    xfer(ACC_OFS, 1'b1, {24'h0, v});
  endtask

  // program counter word
  function automatic logic [31:0] pcw();
    return {16'h0, sp_exp, pc_exp};
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and unmapped place
    rchk("acc_rst", ACC_OFS, 32'h0);
    rchk("status_rst", STATUS_OFS, {24'h0, STATUS_RESET});
    rchk("pc_rst", PC_OFS, pcw());
    xfer(8'h1C, 1'b0, '0);
    check("unmapped_data", 32'h0, rd);
    check("unmapped_err", 32'h1, {31'h0, er});
    $display("test reset done");
    // complement to accumulator and back to register
    setacc(8'h13);
    exec({MOVE_CODE, 7'h20});
    exec({COMPLEMENT_CODE, 1'b0, 7'h20});
    rchk("complement_reg_op_acc", ACC_OFS, 32'hEC);
    rchk("complement_reg_op_z0", STATUS_OFS, 32'h18);
    exec({COMPLEMENT_CODE, 1'b1, 7'h20});
    rchk("complement_reg_op_acc_kept", ACC_OFS, 32'hEC);
    exec({SWAP_CODE, 1'b0, 7'h20});
    rchk("swap_acc", ACC_OFS, 32'hCE);
    setacc(8'hFF);
    exec({MOVE_CODE, 7'h21});
    exec({COMPLEMENT_CODE, 1'b1, 7'h21});
    rchk("complement_reg_op_z1", STATUS_OFS, 32'h1C);
    rchk("complement_reg_op_acc_ff", ACC_OFS, 32'hFF);
    exec({SWAP_CODE, 1'b0, 7'h20});
    rchk("swap_keeps_z1", STATUS_OFS, 32'h1C);
    exec({COMPLEMENT_CODE, 1'b0, 7'h21});
    rchk("complement_reg_op_zero_reg", ACC_OFS, 32'hFF);
    exec({SWAP_CODE, 1'b0, 7'h21});
    rchk("swap_zero_res", ACC_OFS, 32'h00);
    rchk("swap_keeps_z0", STATUS_OFS, 32'h18);
    rchk("pc_steps", PC_OFS, pcw());
    $display("test complement and swap done");
    // bank switch, moves in either bank, watchdog clear
    setacc(8'hA5);
    exec({MOVE_CODE, 7'h30});
    setacc(8'h20);
    exec({MOVE_CODE, STATUS_ADDR});
    rchk("bank1_set", STATUS_OFS, 32'h38);
    setacc(8'h5A);
    exec({MOVE_CODE, 7'h30});
    exec({SWAP_CODE, 1'b0, 7'h30});
    rchk("bank1_swap", ACC_OFS, 32'hA5);
    // context save step: swap status into the accumulator
    exec({SWAP_CODE, 1'b0, STATUS_ADDR});
    rchk("swap_status_acc", ACC_OFS, 32'h83);
    rchk("swap_status_kept", STATUS_OFS, 32'h38);
    repeat (600) @(posedge pclk);
    exec(CLEAR_WDOG_WORD);
    xfer(WDOG_OFS, 1'b0, '0);
    check("wdog_count", 32'h0, {24'h0, rd[7:0]});
    check("wdog_presc", 32'h1, {31'h0, rd[15:8] < 8'h03});
    rchk("wdog_status", STATUS_OFS, 32'h38);
    exec({BIT_CLEAR_CODE, 3'(BANK_BIT), STATUS_ADDR});
    rchk("bank0_sel", STATUS_OFS, 32'h18);
    exec({SWAP_CODE, 1'b0, 7'h30});
    rchk("bank0_swap", ACC_OFS, 32'h5A);
    // swap back into the register, then read it out through the accumulator
    exec({SWAP_CODE, 1'b1, 7'h30});
    rchk("swap_reg_acc_kept", ACC_OFS, 32'h5A);
    exec({SWAP_CODE, 1'b0, 7'h30});
    rchk("swap_reg_back", ACC_OFS, 32'hA5);
    rchk("swap_reg_status", STATUS_OFS, 32'h18);
    $display("test bank and watchdog done");
    // interrupt entry keeps acc and status
    rchk("pc_before", PC_OFS, pcw());
    xfer(CTRL_OFS, 1'b1, 32'h1);
    pc_exp = INT_VECTOR;
    sp_exp = sp_exp + 3'd1;
    rchk("pc_vector", PC_OFS, pcw());
    rchk("acc_kept", ACC_OFS, 32'hA5);
    rchk("status_kept", STATUS_OFS, 32'h18);
    exec(14'h3FFF);
    rchk("noop_acc", ACC_OFS, 32'hA5);
    rchk("pc_after", PC_OFS, pcw());
    $display("test interrupt entry done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
